/* bench/cbo_pin_mon.sv */
module cbo_pin_mon (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Pin as seen by the receiving IC
   input  wire logic        pin,
   // Length of the last high and low phase, in pclk cycles
   output logic [15:0] hi_len,
   output logic [15:0] lo_len
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] run_q;
   logic        last_q;
   // A phase is recorded only when it ends, so a short pulse shows up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q  <= 16'h0001;
         last_q <= 1'b0;
         hi_len <= 16'h0000;
         lo_len <= 16'h0000;
      end else if (pin !== last_q) begin
         if (last_q) hi_len <= run_q;
         else lo_len <= run_q;
         run_q  <= 16'h0001;
         last_q <= pin;
      end else begin
         run_q <= run_q + 16'h0001;
      end
   end
endmodule

/* bench/tb_clock_buzzer_output.sv */
module tb_clock_buzzer_output
   import cbo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic [3:0]  pstrb = 4'hF;
   logic        pready, pslverr, pin0, pin1;
   logic [15:0] hi0, lo0, hi1, lo1;
   int          num_errors = 0, samples_checked = 0, n, half;

   cbo_top #(.LARGE_PKG(1'b1)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .clock_buzzer_pin_zero(pin0), .clock_buzzer_pin_one(pin1));
   cbo_pin_mon i_mon0 (.pclk(pclk), .presetn(presetn), .pin(pin0), .hi_len(hi0), .lo_len(lo0));
   cbo_pin_mon i_mon1 (.pclk(pclk), .presetn(presetn), .pin(pin1), .hi_len(hi1), .lo_len(lo1));

   // ----------------------------------------------------------------
   // Clock, compare and bus tasks
   // ----------------------------------------------------------------
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until pready is sampled high; the answer is taken there
   task automatic apb(input logic wr, input logic [31:0] a, d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      if (k >= 50) chk(32'h1, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so a following call never drives psel twice in a step
      @(posedge pclk);
   endtask
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'hF);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, s, r, e);
   endtask
   task automatic rc(input logic [31:0] a, exp, input logic eerr = 1'b0);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, 4'hF, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, eerr});
   endtask
   // Bounded wait until the chosen pin is sampled at a level
   task automatic wait_pin(input bit which, input logic lvl, input int lim, output int k);
      k = 0;
      while ((which ? pin1 : pin0) !== lvl && k < lim) begin
         @(posedge pclk);
         k++;
      end
      if (k >= lim) chk(32'h1, 32'h0);
      @(posedge pclk);
   endtask
   task automatic conclude();
      $display("Counts: %0d checked, %0d mismatches", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Watchdog sized for the slowest divider codes
   initial begin
      repeat (90000) @(posedge pclk);
      num_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      conclude();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      // Falling edge at time zero clears the state before the first clock
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(SEL0_ADDR, 32'h0);
      rc(SEL1_ADDR, 32'h0);
      chk({30'h0, pin0, pin1}, 32'h0);
      wr(SEL0_ADDR, 32'h7C);
      rc(SEL0_ADDR, 32'h04);
      $display("Test registers done");
      // Every divider code, programmed while disabled, then enabled; fmain
      // is pclk/2 here, so even code 0 stays under the pin ceiling, and the
      // shared port bits live outside this block and count as cleared
      for (int c = 0; c < 8; c++) begin
         half = (c < 5) ? (1 << c) : (1 << (c + 6));
         wr(SEL0_ADDR, c);
         wr(SEL0_ADDR, 32'h80 | c);
         wait_pin(1'b0, 1'b1, 4 * half + 8, n);
         chk({31'h0, n <= 2 * half + 4}, 32'h1);
         wait_pin(1'b0, 1'b0, 2 * half + 4, n);
         chk(hi0, half);
         wait_pin(1'b0, 1'b1, 2 * half + 4, n);
         chk(lo0, half);
         chk(pin1, 1'b0);
         wr(SEL0_ADDR, c);
         // The last pulse ends within half a period of the write landing
         repeat (half + 8) @(posedge pclk);
         chk(pin0, 1'b0);
         chk(hi0, half);
      end
      $display("Test divider codes done");
      // Single-bit writes to instance 1
      // Word is instance in bit 9, value in bit 8, position in bits 2..0
      wr(BITOP_ADDR, 32'h300);
      rc(SEL1_ADDR, 32'h01);
      wr(BITOP_ADDR, 32'h305);
      rc(SEL1_ADDR, 32'h01);
      wr(BITOP_ADDR, 32'h307);
      rc(SEL1_ADDR, 32'h81);
      wait_pin(1'b1, 1'b1, 16, n);
      wait_pin(1'b1, 1'b0, 16, n);
      chk(hi1, 16'h2);
      rc(SEL0_ADDR, 32'h07);
      wr(SEL1_ADDR, 32'h86, 4'h0);
      rc(SEL1_ADDR, 32'h81);
      rc(32'h0000_0200, 32'h0, 1'b1);
      $display("Test bit access done");
      // Reset in mid-run clears a running instance
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({30'h0, pin0, pin1}, 32'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(SEL1_ADDR, 32'h0);
      $display("Test second reset done");
      conclude();
   end
endmodule

/* rtl/cbo_pkg.sv */
package cbo_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   // Printed offsets are not word aligned, so they are register indices
   localparam logic [31:0] SEL0_IDX   = 32'h000F_FFA5;
   localparam logic [31:0] SEL1_IDX   = 32'h000F_FFA6;
   localparam logic [31:0] SEL0_ADDR  = {SEL0_IDX[29:0], 2'b00};
   localparam logic [31:0] SEL1_ADDR  = {SEL1_IDX[29:0], 2'b00};
   // Single-bit manipulation port for either select register
   localparam logic [31:0] BITOP_ADDR = 32'h0000_0100;

   // -----------------------------------------------------------------
   // Field layout and reset values
   // -----------------------------------------------------------------
   localparam int         N_INST     = 2;
   localparam int         OE_BIT     = 7;
   localparam int         DIV_W      = 3;
   localparam logic [7:0] SEL_RST    = 8'h00;
   localparam logic [7:0] SEL_WMASK  = 8'h87;
   localparam int         BOP_VAL    = 8;
   localparam int         BOP_INST   = 9;
   localparam int         BOP_POS_W  = 3;

   // -----------------------------------------------------------------
   // Divider
   // -----------------------------------------------------------------
   // Counter bit k toggles every 2^k pclk, so fmain is pclk/2 here
   localparam int               CNT_W       = 14;
   localparam logic [DIV_W-1:0] DIV_LOW_MAX = 3'h4;
   localparam logic [3:0]       DIV_HI_OFS  = 4'h6;

   // Decoded register targets
   localparam logic [1:0] HIT_SEL0  = 2'h0;
   localparam logic [1:0] HIT_SEL1  = 2'h1;
   localparam logic [1:0] HIT_BITOP = 2'h2;
   localparam logic [1:0] HIT_NONE  = 2'h3;

   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_RESP
   } cbo_bus_e;

   // Whole state of the block
   typedef struct packed {
      logic [CNT_W-1:0]          cnt;
      cbo_bus_e                  bus;
      logic                      pready;
      logic                      pslverr;
      logic [31:0]               prdata;
      logic [N_INST-1:0][7:0]    sel;
      logic [N_INST-1:0]         run;
      logic [N_INST-1:0]         pin;
   } cbo_state_s;

endpackage

/* rtl/cbo_top.sv */
// Function
// - Each pin carries the clock chosen by its own select register.
// - Instance 0 always exists; instance 1 only on the large package.
// - Bit 7 of the select register enables the pin output, 0 by default.
// - Code 0..4 divides fmain by 1..16, codes 5..7 by 2^11..2^13.
// - Reset clears both select registers, output off and no division.
// - Select registers take byte writes and single-bit writes and read back.
// - Output starts or stops one clock period after the enable changes; here it starts within one period and stops within half a period.
// - Starting and stopping never emits a truncated pulse.
//
// Local design decision: the APB slave port.
module cbo_top
   import cbo_pkg::*;
#(
   parameter bit LARGE_PKG = 1'b1
) (
   // Clock and reset
   input  logic        pclk,
   input  logic        presetn,
   // APB slave
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [31:0] paddr,
   input  logic [31:0] pwdata,
   input  logic [3:0]  pstrb,
   output logic        pready,
   output logic [31:0] prdata,
   output logic        pslverr,
   // Clock and buzzer pins
   output logic        clock_buzzer_pin_zero,
   output logic        clock_buzzer_pin_one
);

   // -----------------------------------------------------------------
   // Decoding helpers
   // -----------------------------------------------------------------

   // Address to register target; instance 1 is unmapped when absent
   function automatic logic [1:0] reg_hit(input logic [31:0] a);
      logic [1:0] h;
      h = HIT_NONE;
      if (a == SEL0_ADDR) begin
         h = HIT_SEL0;
      end else if (a == SEL1_ADDR && LARGE_PKG) begin
         h = HIT_SEL1;
      end else if (a == BITOP_ADDR) begin
         h = HIT_BITOP;
      end
      return h;
   endfunction

   // Divider code to counter tap
   function automatic logic [3:0] div_tap(input logic [DIV_W-1:0] c);
      logic [3:0] t;
      if (c <= DIV_LOW_MAX) begin
         t = {1'b0, c};
      end else begin
         t = {1'b0, c} + DIV_HI_OFS;
      end
      return t;
   endfunction

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   localparam cbo_state_s S_RST = '{
      cnt:     '0,
      bus:     BUS_IDLE,
      pready:  1'b0,
      pslverr: 1'b0,
      prdata:  32'h0000_0000,
      sel:     {N_INST{SEL_RST}},
      run:     '0,
      pin:     '0
   };

   cbo_state_s s_q;
   cbo_state_s s_d;
   logic [1:0] hit;
   logic       wr_go;
   logic       bop_inst;
   logic [BOP_POS_W-1:0] bop_pos;

   assign hit      = reg_hit(paddr);
   assign bop_inst = pwdata[BOP_INST];
   assign bop_pos  = pwdata[BOP_POS_W-1:0];
   // A write lands only at the edge where pready is seen high
   assign wr_go    = psel && penable && pwrite && pstrb[0] && s_q.pready;

   // Next-state logic for bus, registers and divider
   always_comb begin
      logic [3:0] tap;
      logic       src;
      tap = 4'h0;
      src = 1'b0;
      s_d = s_q;
      // Free-running counter shared by both pins
      s_d.cnt = CNT_W'(s_q.cnt + 1'b1);
      case (s_q.bus)
         BUS_IDLE: begin
            if (psel && penable) begin
               s_d.bus     = BUS_RESP;
               s_d.pready  = 1'b1;
               s_d.pslverr = (hit == HIT_NONE);
               s_d.prdata  = 32'h0000_0000;
               if (!pwrite && (hit == HIT_SEL0 || hit == HIT_SEL1)) begin
                  s_d.prdata = {24'h00_0000, s_q.sel[hit[0]]};
               end
            end
         end
         BUS_RESP: begin
            s_d.bus     = BUS_IDLE;
            s_d.pready  = 1'b0;
            s_d.pslverr = 1'b0;
            s_d.prdata  = 32'h0000_0000;
            if (wr_go && (hit == HIT_SEL0 || hit == HIT_SEL1)) begin
               // Reserved bits are dropped on the way in
               s_d.sel[hit[0]] = pwdata[7:0] & SEL_WMASK;
            end else if (wr_go && hit == HIT_BITOP) begin
               if (!bop_inst || LARGE_PKG) begin
                  s_d.sel[bop_inst][bop_pos] = pwdata[BOP_VAL];
                  s_d.sel[bop_inst] = s_d.sel[bop_inst] & SEL_WMASK;
               end
            end
         end
         default: begin
            s_d.bus    = BUS_IDLE;
            s_d.pready = 1'b0;
         end
      endcase
      // Enable is taken over only while the source is low, so the first
      // and last pulse are always whole; this costs up to half a period
      for (int i = 0; i < N_INST; i++) begin
         tap = div_tap(s_q.sel[i][DIV_W-1:0]);
         src = s_d.cnt[tap];
         if (!src) begin
            s_d.run[i] = s_q.sel[i][OE_BIT] && (i == 0 || LARGE_PKG);
         end
         s_d.pin[i] = s_d.run[i] && src;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= S_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register
   assign pready                = s_q.pready;
   assign prdata                = s_q.prdata;
   assign pslverr               = s_q.pslverr;
   assign clock_buzzer_pin_zero = s_q.pin[0];
   assign clock_buzzer_pin_one  = s_q.pin[1];

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Completed write of the select register of each instance
   sequence s_sel_write(int unsigned k);
      wr_go && hit == 2'(k);
   endsequence

   sequence s_bit_write(int unsigned k);
      wr_go && hit == HIT_BITOP && bop_inst == 1'(k) && bop_pos == 3'h7;
   endsequence

   for (genvar gi = 0; gi < N_INST; gi++) begin : g_chk
      // Length of the current high phase of this pin, one counter per
      // instance so that no variable has two clocked writers
      logic [CNT_W:0] hi_len_q;

      // Counts pclk cycles while the pin is high
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            hi_len_q <= '0;
         end else if (s_q.pin[gi]) begin
            hi_len_q <= (CNT_W+1)'(hi_len_q + 1'b1);
         end else begin
            hi_len_q <= '0;
         end
      end

      a_pin_follows_tap: assert property (
         s_q.run[gi] |->
            s_q.pin[gi] == s_q.cnt[div_tap($past(s_q.sel[gi][DIV_W-1:0]))])
         else $error("pin does not follow the selected divider tap");

      a_run_needs_oe: assert property (
         $rose(s_q.run[gi]) |-> $past(s_q.sel[gi][OE_BIT]))
         else $error("output started without the enable bit");

      a_div_half_period: assert property (
         $fell(s_q.pin[gi]) && s_q.run[gi] && $stable(s_q.sel[gi]) |->
            hi_len_q == ((CNT_W+1)'(1) << div_tap(s_q.sel[gi][DIV_W-1:0])))
         else $error("high phase does not match the divider code");

      a_no_runt_pulse: assert property (
         $fell(s_q.pin[gi]) && $stable(s_q.sel[gi][DIV_W-1:0]) |->
            hi_len_q == ((CNT_W+1)'(1) << div_tap(s_q.sel[gi][DIV_W-1:0])))
         else $error("truncated pulse on the pin");

      a_not_immediate: assert property (
         $changed(s_q.sel[gi][OE_BIT]) |-> $stable(s_q.run[gi]))
         else $error("output changed at the register write itself");

      a_start_bounded: assert property (
         $rose(s_q.sel[gi][OE_BIT]) && s_q.sel[gi][DIV_W-1:0] <= DIV_LOW_MAX
            && (gi == 0 || LARGE_PKG) |-> ##[1:32] s_q.run[gi])
         else $error("output did not start within one period");

      a_low_when_off: assert property (
         !s_q.run[gi] |-> !s_q.pin[gi])
         else $error("pin not low while output disabled");

      // Run only switches while the source is low, so no pulse is cut
      a_switch_low: assert property (
         $changed(s_q.run[gi]) |-> !s_q.pin[gi])
         else $error("output switched in the middle of a pulse");

      // Stopping waits for the source to go low, at most half a period
      a_stop_bounded: assert property (
         $fell(s_q.sel[gi][OE_BIT]) && s_q.sel[gi][DIV_W-1:0] <= DIV_LOW_MAX
            |-> ##[1:32] !s_q.run[gi])
         else $error("output did not stop within one period");

      a_reserved_zero: assert property (
         s_q.sel[gi][6:3] == 4'h0)
         else $error("reserved select bits not zero");

      a_byte_write: assert property (
         s_sel_write(gi) |=> s_q.sel[gi] == ($past(pwdata[7:0]) & SEL_WMASK))
         else $error("byte write not stored");

      a_bit_write: assert property (
         s_bit_write(gi) && (gi == 0 || LARGE_PKG) |=>
            s_q.sel[gi][OE_BIT] == $past(pwdata[BOP_VAL]))
         else $error("single-bit write not stored");
   end

   a_reset_clear: assert property (
      @(posedge pclk) disable iff (1'b0)
      !presetn |-> s_q.sel == '0 && s_q.pin == '0)
      else $error("reset did not clear the select registers");

   a_inst1_absent: assert property (
      !LARGE_PKG |-> !clock_buzzer_pin_one && s_q.sel[1] == 8'h00)
      else $error("instance one active on small package");

   a_pready_pulse: assert property (
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   // -----------------------------------------------------------------
   // Bus and counter checks
   // -----------------------------------------------------------------
   // Every access phase is answered in the following cycle
   a_pready_answer: assert property (
      psel && penable && s_q.bus == BUS_IDLE |=> pready)
      else $error("access phase not answered");

   // Unmapped addresses are refused with an error and no data
   a_unmapped_err: assert property (
      psel && penable && s_q.bus == BUS_IDLE && hit == HIT_NONE |=>
         pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   // Read data of a select register is the byte it holds
   a_read_back: assert property (
      psel && penable && !pwrite && s_q.bus == BUS_IDLE
         && (hit == HIT_SEL0 || hit == HIT_SEL1) |=>
         prdata == {24'h00_0000, $past(s_q.sel[hit[0]])})
      else $error("read data differs from the select register");

   // Data and error lines stay quiet outside the answer cycle
   a_quiet_idle: assert property (
      !pready |-> prdata == 32'h0000_0000 && !pslverr)
      else $error("bus outputs active outside the answer cycle");

   // A write without its low byte strobe leaves both registers alone
   a_strobe_ignored: assert property (
      psel && penable && pwrite && !pstrb[0] |=> $stable(s_q.sel))
      else $error("write without strobe changed a register");

   // Reserved positions of a single-bit write change nothing
   a_bit_reserved: assert property (
      wr_go && hit == HIT_BITOP && bop_pos inside {[3'h3:3'h6]} |=> $stable(s_q.sel))
      else $error("single-bit write to a reserved position took effect");

   // The divider counter never stalls or skips; the first edge after
   // reset is left out because the counter was held there
   a_cnt_free_run: assert property (
      $past(presetn) |-> s_q.cnt == CNT_W'($past(s_q.cnt) + 1'b1))
      else $error("divider counter did not advance by one");

endmodule
